/* File: core/i2c_slave_map.vh */
`ifndef I2C_SLAVE_MAP_VH
`define I2C_SLAVE_MAP_VH

// Register byte offsets on the AXI4-Lite bus.
`define OFS_MODE 4'h0
`define OFS_STATUS 4'h4
`define OFS_MASK 4'h8

// Mode register field positions.
`define MODE_START_IRQ_EN 6
`define MODE_STOP_IRQ_EN 5
`define MODE_RESTART_SEL 4
`define MODE_NACK_WAIT_SEL 3
`define MODE_STOP_SCOPE 2
`define MODE_UNIT_EN 0
`define MODE_WRITABLE 16'h007D
`define MODE_RESET 16'h0000

// Status register field positions, shared by the mask register.
`define STAT_START_SEEN 11
`define STAT_STOP_SEEN 10
`define STAT_ADDR_ACK 3
`define STAT_IMPLEMENTED 16'h0C08
`define STAT_RESET 16'h0000
`define MASK_RESET 16'h0000

// AXI response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: core/i2c_slave_mode_control.v */
// How it works
// - Mode bit 6 enables start-condition interrupt; reset value zero means disabled.
// - Mode bit 5 enables stop-condition interrupt; reset value zero means disabled.
// - Mode bit 2 set limits stop interrupt to traffic addressed to this slave.
// - Writing one to mode bit 0 starts slave operation; reset leaves it stopped.
// - Writing zero to the enable bit stops the unit and zeroes all status bits.
// - Start-seen flag, status bit 11, sets on a received start condition while mode bit 6 is set.
// - Stop-seen flag, status bit 10, sets on a received stop condition while mode bit 5 is set and bit 2 scope allows it.
`include "i2c_slave_map.vh"

module i2c_slave_mode_control (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // I2C bus lines, sampled only
   input wire scl_in,
   input wire sda_in,
   // Address matcher, one-cycle pulse on an acknowledged own address
   input wire addr_match,
   // Configuration to the rest of the unit
   output reg slave_unit_enable,
   output reg restart_irq_select,
   output reg nack_wait_select,
   // Interrupt
   output reg irq
);

   reg [15:0] slave_mode_control;
   reg [15:0] bus_status_register;
   reg [15:0] irq_mask;

   reg aw_full;
   reg w_full;
   reg [3:0] wr_addr;
   reg [31:0] wr_data;
   reg [3:0] wr_strb;

   // The first stage of each synchroniser feeds only the second stage.
   reg scl_meta;
   reg scl_sync;
   reg scl_prev;
   reg sda_meta;
   reg sda_sync;
   reg sda_prev;

   wire wr_commit = aw_full & w_full;
   wire rd_take = s_axi_arvalid & s_axi_arready;
   wire [3:0] rd_addr = s_axi_araddr[3:0];
   wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire wr_mode = wr_commit & (wr_addr == `OFS_MODE);
   wire wr_mask = wr_commit & (wr_addr == `OFS_MASK);
   wire wr_ok = wr_mode | wr_mask | (wr_addr == `OFS_STATUS);
   wire [15:0] mode_written = (slave_mode_control & ~lane_mask) |
      (wr_data[15:0] & lane_mask & `MODE_WRITABLE);
   wire [15:0] mask_written = (irq_mask & ~lane_mask) |
      (wr_data[15:0] & lane_mask & `STAT_IMPLEMENTED);

   // A write of zero to the enable lane takes the unit down at once.
   wire disable_write = wr_mode & wr_strb[0] & ~wr_data[`MODE_UNIT_EN];

   wire running = slave_mode_control[`MODE_UNIT_EN];
   wire start_cond = running & scl_sync & scl_prev & sda_prev & ~sda_sync;
   wire stop_cond = running & scl_sync & scl_prev & ~sda_prev & sda_sync;

   wire stop_in_scope = ~slave_mode_control[`MODE_STOP_SCOPE] |
      bus_status_register[`STAT_ADDR_ACK];

   reg [15:0] status_set;
   reg [15:0] next_status;
   reg [15:0] next_mode;
   reg [15:0] next_mask;

   always @* begin
      status_set = 16'h0000;
      status_set[`STAT_START_SEEN] = start_cond &
         slave_mode_control[`MODE_START_IRQ_EN];
      status_set[`STAT_STOP_SEEN] = stop_cond &
         slave_mode_control[`MODE_STOP_IRQ_EN] & stop_in_scope;
      status_set[`STAT_ADDR_ACK] = running & addr_match;
      // A read at the status offset clears the flags, but an event in the same cycle survives it.
      if (rd_take && rd_addr == `OFS_STATUS) begin
         next_status = status_set;
      end else begin
         next_status = bus_status_register | status_set;
      end
      if (disable_write) begin
         next_status = `STAT_RESET;
      end
      next_mode = wr_mode ? mode_written : slave_mode_control;
      next_mask = wr_mask ? mask_written : irq_mask;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_meta <= scl_in;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= sda_in;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         slave_mode_control <= `MODE_RESET;
         bus_status_register <= `STAT_RESET;
         irq_mask <= `MASK_RESET;
         slave_unit_enable <= 1'b0;
         restart_irq_select <= 1'b0;
         nack_wait_select <= 1'b0;
         irq <= 1'b0;
      end else begin
         slave_mode_control <= next_mode;
         bus_status_register <= next_status;
         irq_mask <= next_mask;
         slave_unit_enable <= next_mode[`MODE_UNIT_EN];
         restart_irq_select <= next_mode[`MODE_RESTART_SEL];
         nack_wait_select <= next_mode[`MODE_NACK_WAIT_SEL];
         irq <= |(next_status & next_mask);
      end
   end

   // Write path: address and data are held independently, so either may come first.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         wr_addr <= 4'h0;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            s_axi_awready <= 1'b0;
            // Upper address bits must be zero for a register to match.
            wr_addr <= (s_axi_awaddr[31:4] == 28'h0000000) ? s_axi_awaddr[3:0] : 4'hF;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            s_axi_wready <= 1'b0;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (wr_commit) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr[31:4] != 28'h0000000) begin
               s_axi_rresp <= `RESP_SLVERR;
            end else begin
               case (rd_addr)
                  `OFS_MODE: begin
                     s_axi_rdata <= {16'h0000, slave_mode_control};
                  end
                  `OFS_STATUS: begin
                     s_axi_rdata <= {16'h0000, bus_status_register};
                  end
                  `OFS_MASK: begin
                     s_axi_rdata <= {16'h0000, irq_mask};
                  end
                  default: begin
                     s_axi_rresp <= `RESP_SLVERR;
                  end
               endcase
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

/* File: test/i2c_slave_mode_control_sva.sv */
module i2c_slave_mode_control_sva (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Register bus
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // Link and results
   input wire sda_in,
   input wire addr_match,
   input wire slave_unit_enable,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Only a status read or a committed write may lower the interrupt.
   // A read clears at its address edge; a write shows as bvalid one edge after commit.
   sequence held_irq;
      irq && !(s_axi_arvalid && s_axi_arready) ##1 !s_axi_bvalid;
   endsequence
   a_reset_quiet: assert property (!$past(aresetn) |-> !irq && !slave_unit_enable)
      else $error("outputs not idle after reset");
   a_off_quiet: assert property (!slave_unit_enable |-> !irq)
      else $error("interrupt while unit stopped");
   a_stop_clears: assert property ($fell(slave_unit_enable) |-> !irq ##1 !irq)
      else $error("interrupt survived disable");
   a_spare_zero: assert property (s_axi_rvalid |->
      s_axi_rdata[31:12] == 20'h0 && s_axi_rdata[9:7] == 3'h0 && !s_axi_rdata[1])
      else $error("reserved read bit set");
   a_flag_sticky: assert property (held_irq |-> irq)
      else $error("interrupt dropped without cause");
   a_irq_cause: assert property ($rose(irq) |->
      s_axi_bvalid || $past(addr_match) || $past(sda_in) != $past(sda_in, 4))
      else $error("interrupt rose without cause");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
endmodule
bind i2c_slave_mode_control i2c_slave_mode_control_sva chk (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .sda_in(sda_in),
   .addr_match(addr_match),
   .slave_unit_enable(slave_unit_enable),
   .irq(irq)
);

/* File: test/i2c_master_model.sv */
module i2c_master_model (
   // Clock and bus lines
   input wire aclk,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   // Both lines idle high through their pull-ups; SCL stands still between frames.
   initial {scl, sda} = 2'h3;
   task automatic half;
      repeat (4) @(posedge aclk);
   endtask
   task automatic frame;
      half();
      sda <= 1'h0;
      half();
      scl <= 1'h0;
      half();
      scl <= 1'h1;
      half();
      sda <= 1'h1;
      half();
   endtask
endmodule

/* File: test/i2c_slave_mode_control_test.sv */
`include "i2c_slave_map.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end

module i2c_slave_mode_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, addr_match = 0, scl_in, sda_in, irq;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic slave_unit_enable, restart_irq_select, nack_wait_select;
   wire [2:0] cfg_out = {restart_irq_select, nack_wait_select, slave_unit_enable};
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] md [7] = '{16'h61, 16'h1, 16'h41, 16'h21, 16'h25, 16'h25, 16'h20};
   logic [15:0] st [7] = '{16'hC00, 16'h0, 16'h800, 16'h400, 16'h0, 16'h408, 16'h0};
   logic [6:0] am = 7'h60;
   int mismatches = 0, n_checks = 0;
   i2c_slave_mode_control dut (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .addr_match(addr_match),
      .slave_unit_enable(slave_unit_enable),
      .restart_irq_select(restart_irq_select),
      .nack_wait_select(nack_wait_select),
      .irq(irq)
   );
   i2c_master_model peer (.aclk(aclk), .scl(scl_in), .sda(sda_in));
   initial forever #50 aclk = ~aclk;
   task automatic wr(input logic [31:0] a, d, input logic [1:0] r = 2'h0);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      `CHK(s_axi_bresp, r)
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [31:0] a, e, input logic [1:0] r = 2'h0);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      `CHK(s_axi_rdata, e)
      `CHK(s_axi_rresp, r)
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(`OFS_MODE, 0);
      rd(`OFS_STATUS, 0);
      wr(`OFS_MODE, 32'hFFFF);
      rd(`OFS_MODE, 32'h7D);
      `CHK({restart_irq_select, nack_wait_select, slave_unit_enable}, 3'h7)
      wr(32'h10, 0, `RESP_SLVERR);
      rd(32'h10, 0, `RESP_SLVERR);
      // The status register is read-only: a write is accepted and changes nothing.
      wr(`OFS_STATUS, 32'hFFFF);
      rd(`OFS_STATUS, 0);
      wr(`OFS_MASK, 32'hFFFF);
      rd(`OFS_MASK, 32'hC08);
      for (int i = 0; i < 7; i++) begin
         wr(`OFS_MODE, md[i]);
         `CHK(cfg_out, {md[i][4:3], md[i][0]})
         if (am[i]) begin
            addr_match <= 1;
            @(posedge aclk);
            addr_match <= 0;
         end
         // Status is read only after the stop, so a scoped stop still sees the address-ack flag.
         peer.frame();
         `CHK(irq, st[i] != 0)
         rd(`OFS_STATUS, st[i]);
         rd(`OFS_STATUS, 0);
      end
      // Masked flags must stay pending so a later unmask still reports them.
      wr(`OFS_MASK, 0);
      wr(`OFS_MODE, 32'h61);
      peer.frame();
      `CHK(irq, 1'h0)
      wr(`OFS_MASK, 32'hC00);
      `CHK(irq, 1'h1)
      // Stopping the unit is also what software does before any standby.
      wr(`OFS_MODE, 0);
      `CHK({irq, slave_unit_enable}, 2'h0)
      rd(`OFS_STATUS, 0);
      conclude();
   end
endmodule
